// ---- verilog/rtc_defs.svh ----
// register indices, field positions and timing counts for the divider and rate control
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define RTC_IDX_DIV_RATE 8'h0A
`define RTC_IDX_CONFIG 8'h0B
`define RTC_IDX_FLAGS 8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define RTC_UIP_BIT 7
`define RTC_DV_HI 6
`define RTC_DV_LO 4
`define RTC_RS_HI 3
`define RTC_RS_LO 0
`define RTC_PIE_BIT 6
`define RTC_PF_BIT 6
`define RTC_CFG_RSM_MASK 8'h78
`define RTC_CFG_RESET 8'h00

// ----------------------------------------
// divider chain and timing
// ----------------------------------------
`define RTC_OSC_HZ 32768
`define RTC_CHAIN_BITS 15
`define RTC_UIP_LEAD_NS 244000
`define RTC_UIP_LEAD_TICKS ((64'd`RTC_UIP_LEAD_NS * 64'd`RTC_OSC_HZ + 64'd999999999) / 64'd1000000000)
`define RTC_UPD_TICKS 4'h2

`endif

// ---- verilog/rtc_pkg.sv ----
// types shared by the divider and rate control logic
package rtc_pkg;

	typedef enum logic [0:0] {
		UPD_IDLE = 1'b0,
		UPD_BUSY = 1'b1
	} upd_state_e;

	typedef logic [2:0] div_sel_t;
	typedef logic [3:0] rate_sel_t;

endpackage : rtc_pkg

// ---- verilog/rtc_divider_rate_ctrl.sv ----
// divider chain, periodic rate tap, update-pending status and their registers
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_divider_rate_ctrl
	import rtc_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// oscillator and resume reset pins
	input wire logic i_osc_32k,
	input wire logic i_rsm_rst_n,
	// indexed register access
	input wire logic [7:0] i_reg_index,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// status and events
	output logic o_update_pending,
	output logic o_update_busy,
	output logic o_update_start,
	output logic o_periodic_irq
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [15:0] chain_step(input div_sel_t dv);
		case (dv)
			3'h2: chain_step = 16'h0001;
			3'h3: chain_step = 16'h0020;
			3'h4: chain_step = 16'h0400;
			3'h5: chain_step = 16'h8000;
			default: chain_step = 16'h0000;
		endcase
	endfunction : chain_step

	function automatic logic [3:0] tap_width(input rate_sel_t rs);
		case (rs)
			4'h0: tap_width = 4'h0;
			4'h1: tap_width = 4'h7;
			4'h2: tap_width = 4'h8;
			default: tap_width = rs - 4'h1;
		endcase
	endfunction : tap_width

	// true when the chain wraps within the pending lead time at this step size
	function automatic logic near_wrap(input logic [14:0] cnt, input logic [15:0] stp);
		logic [18:0] ahead;
		ahead = {4'h0, cnt} + ({3'h0, stp} * 19'(`RTC_UIP_LEAD_TICKS));
		near_wrap = (ahead >= 19'h08000);
	endfunction : near_wrap

	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
	logic rsm_s1_ff, rsm_s2_ff;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			osc_s1_ff <= 1'b0;
			osc_s2_ff <= 1'b0;
			osc_s3_ff <= 1'b0;
			rsm_s1_ff <= 1'b1;
			rsm_s2_ff <= 1'b1;
		end else begin
			osc_s1_ff <= i_osc_32k;
			osc_s2_ff <= osc_s1_ff;
			osc_s3_ff <= osc_s2_ff;
			rsm_s1_ff <= i_rsm_rst_n;
			rsm_s2_ff <= rsm_s1_ff;
		end
	end

	wire osc_tick = osc_s2_ff & ~osc_s3_ff;
	wire rsm_active = ~rsm_s2_ff;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	div_sel_t dv_ff;
	rate_sel_t rs_ff;
	logic [7:0] cfg_ff;
	logic pf_ff, irq_ff, uip_ff, start_ff;
	logic [7:0] rdata_ff;

	wire wr_a = i_reg_wr & (i_reg_index == `RTC_IDX_DIV_RATE);
	wire wr_b = i_reg_wr & (i_reg_index == `RTC_IDX_CONFIG);
	wire rd_c = i_reg_rd & (i_reg_index == `RTC_IDX_FLAGS);
	wire periodic_irq_enable = cfg_ff[`RTC_PIE_BIT];

	// divider and rate register has no reset at all
	always_ff @(posedge i_clock) begin
		if (wr_a) begin
			dv_ff <= i_reg_wdata[`RTC_DV_HI:`RTC_DV_LO];
			rs_ff <= i_reg_wdata[`RTC_RS_HI:`RTC_RS_LO];
		end
	end

	logic [7:0] nxt_rdata;
	always_comb begin
		nxt_rdata = 8'h00;
		case (i_reg_index)
			`RTC_IDX_DIV_RATE: nxt_rdata = {uip_ff, dv_ff, rs_ff};
			`RTC_IDX_CONFIG: nxt_rdata = cfg_ff;
			`RTC_IDX_FLAGS: nxt_rdata[`RTC_PF_BIT] = pf_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
			cfg_ff <= `RTC_CFG_RESET;
		end else begin
			if (i_reg_rd) begin
				rdata_ff <= nxt_rdata;
			end
			if (rsm_active) begin
				cfg_ff <= cfg_ff & ~`RTC_CFG_RSM_MASK;
			end else if (wr_b) begin
				cfg_ff <= i_reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// divider chain
	// ----------------------------------------
	logic [14:0] cnt_ff;
	logic [3:0] upd_cnt_ff;
	upd_state_e upd_state_ff;

	wire [15:0] step = chain_step(dv_ff);
	// mode in force next cycle, so pending never lags a divider write
	wire [2:0] nxt_dv = wr_a ? i_reg_wdata[`RTC_DV_HI:`RTC_DV_LO] : dv_ff;
	wire [15:0] nxt_step = chain_step(nxt_dv);
	wire chain_hold = (dv_ff[2:1] == 2'h3);
	wire running = (step != 16'h0000) & ~chain_hold;
	wire [15:0] sum = {1'b0, cnt_ff} + step;
	wire advance = osc_tick & running;
	wire wrap = advance & sum[15];
	wire [14:0] nxt_cnt = chain_hold ? 15'h0000 : (advance ? sum[14:0] : cnt_ff);
	wire [3:0] tap_k = tap_width(rs_ff);
	wire [15:0] tap_mask = (16'h0001 << tap_k) - 16'h0001;
	wire periodic_ev = advance & (tap_k != 4'h0) & ((sum & tap_mask) == 16'h0000);

	upd_state_e nxt_upd_state;
	logic [3:0] nxt_upd_cnt;
	always_comb begin
		nxt_upd_state = upd_state_ff;
		nxt_upd_cnt = upd_cnt_ff;
		case (upd_state_ff)
			UPD_IDLE: begin
				if (wrap) begin
					nxt_upd_state = UPD_BUSY;
					nxt_upd_cnt = `RTC_UPD_TICKS;
				end
			end
			UPD_BUSY: begin
				if (osc_tick) begin
					nxt_upd_cnt = upd_cnt_ff - 4'h1;
					if (upd_cnt_ff == 4'h1) begin
						nxt_upd_state = UPD_IDLE;
					end
				end
			end
			default: nxt_upd_state = UPD_IDLE;
		endcase
	end

	// pending starts a full lead time before the wrap and covers the busy phase
	// held and invalid modes have a zero step and so never look near a wrap
	wire nxt_uip = (nxt_upd_state == UPD_BUSY) | near_wrap(nxt_cnt, nxt_step);

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 15'h0000;
			upd_cnt_ff <= 4'h0;
			upd_state_ff <= UPD_IDLE;
			uip_ff <= 1'b0;
			start_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			upd_cnt_ff <= nxt_upd_cnt;
			upd_state_ff <= nxt_upd_state;
			uip_ff <= nxt_uip;
			start_ff <= wrap;
		end
	end

	// ----------------------------------------
	// periodic flag and interrupt
	// ----------------------------------------
	wire flag_clear = rd_c | rsm_active;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			pf_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			pf_ff <= periodic_ev | (pf_ff & ~flag_clear);
			irq_ff <= (periodic_ev & periodic_irq_enable) | (irq_ff & ~flag_clear);
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_update_pending = uip_ff;
	assign o_update_busy = upd_state_ff;
	assign o_update_start = start_ff;
	assign o_periodic_irq = irq_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!rst_n);

	a_uip_covers_busy: assert property (upd_state_ff == UPD_BUSY |-> uip_ff)
		else $error("update busy without pending flag");
	a_uip_before_start: assert property ($rose(upd_state_ff == UPD_BUSY) |-> $past(uip_ff))
		else $error("update began without prior pending flag");
	a_uip_zero_safe: assert property (!uip_ff && running && upd_state_ff == UPD_IDLE |-> !near_wrap(cnt_ff, step))
		else $error("pending flag low too close to update");
	a_hold_clears_chain: assert property (chain_hold |=> cnt_ff == 15'h0000 && (!pf_ff || $past(pf_ff)))
		else $error("chain advanced while held");
	a_bypass_five: assert property (osc_tick && dv_ff == 3'h3 |=> cnt_ff[4:0] == $past(cnt_ff[4:0]))
		else $error("low stages moved in bypass-five mode");
	a_rate_none: assert property (rs_ff == 4'h0 |-> !periodic_ev)
		else $error("periodic event with rate zero");
	a_flag_on_event: assert property (periodic_ev |=> pf_ff)
		else $error("periodic flag not set on event");
	a_irq_needs_enable: assert property ($rose(irq_ff) |-> $past(periodic_irq_enable) && $past(periodic_ev))
		else $error("interrupt raised without enable");
	a_read_clears: assert property (rd_c && !periodic_ev |=> !pf_ff && !irq_ff)
		else $error("flag read did not clear flags");
	a_write_fields: assert property (wr_a |=> dv_ff == $past(i_reg_wdata[6:4]) && rs_ff == $past(i_reg_wdata[3:0]))
		else $error("divider and rate fields not written");

	c_update_run: cover property ($rose(upd_state_ff == UPD_BUSY));
	c_periodic_irq: cover property ($rose(irq_ff));
	c_flag_read: cover property (rd_c && pf_ff);

endmodule : rtc_divider_rate_ctrl

// ---- testbench/rtc_divider_rate_ctrl_tb.sv ----
// self-checking bench for the divider and rate control register
`timescale 1ns/1ps

module rtc_divider_rate_ctrl_tb;
	import rtc_pkg::*;

	logic i_clock;
	logic i_arst_n;
	logic i_osc_32k;
	logic i_rsm_rst_n;
	logic [7:0] i_reg_index;
	logic i_reg_wr;
	logic i_reg_rd;
	logic [7:0] i_reg_wdata;
	logic [7:0] o_reg_rdata;
	logic o_update_pending;
	logic o_update_busy;
	logic o_update_start;
	logic o_periodic_irq;
	int miscompares;
	int n_tests;
	logic [7:0] rv;
	logic got_start;
	logic pend_at;
	logic busy_at;
	logic irq_seen;
	// index, write data, expected read back
	logic [23:0] rows [5] = '{24'h0AA626, 24'h0A7070, 24'h0B5A5A, 24'h0DFF00, 24'h0A2323};

	rtc_divider_rate_ctrl rtc_divider_rate_ctrl_inst (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_osc_32k(i_osc_32k),
		.i_rsm_rst_n(i_rsm_rst_n),
		.i_reg_index(i_reg_index),
		.i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd),
		.i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata),
		.o_update_pending(o_update_pending),
		.o_update_busy(o_update_busy),
		.o_update_start(o_update_start),
		.o_periodic_irq(o_periodic_irq)
	);

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8

	task chk1(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask : chk1

	task wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_wr <= 1'b1;
		i_reg_index <= idx;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] idx);
		@(posedge i_clock);
		i_reg_rd <= 1'b1;
		i_reg_index <= idx;
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
		@(posedge i_clock);
		#1 rv = o_reg_rdata;
	endtask : rd

	// oscillator toggles every 4 clocks; n a multiple of 8 leaves it low
	task run(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge i_clock);
			if (k % 4 == 0) i_osc_32k <= ~i_osc_32k;
			#1;
			if (o_periodic_irq === 1'b1) irq_seen = 1'b1;
			if (o_update_start === 1'b1 && got_start !== 1'b1) begin
				got_start = 1'b1;
				pend_at = o_update_pending;
				busy_at = o_update_busy;
			end
		end
	endtask : run

	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		i_arst_n = 1'b0;
		i_osc_32k = 1'b0;
		i_rsm_rst_n = 1'b1;
		i_reg_index = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_wdata = 8'h00;
		miscompares = 0;
		n_tests = 0;
		irq_seen = 1'b0;
		got_start = 1'b0;
		repeat (12) @(posedge i_clock);
		chk1("irq in reset", 1'b0, o_periodic_irq);
		i_arst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16]);
			chk8("readback", rows[i][7:0], rv);
		end
		chk1("pending idle", 1'b0, o_update_pending);
		// system reset leaves the divider and rate register alone
		@(posedge i_clock);
		i_arst_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		i_arst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		rd(8'h0A);
		chk8("div rate after reset", 8'h23, rv);
		wr(8'h0B, 8'h00);
		run(128);
		chk1("irq disabled", 1'b0, irq_seen);
		rd(8'h0C);
		chk8("flag set", 8'h40, rv);
		rd(8'h0C);
		chk8("flag cleared", 8'h00, rv);
		wr(8'h0B, 8'h40);
		run(128);
		chk1("irq enabled", 1'b1, irq_seen);
		chk1("irq level", 1'b1, o_periodic_irq);
		rd(8'h0C);
		chk8("flag with irq", 8'h40, rv);
		chk1("irq after read", 1'b0, o_periodic_irq);
		// resume reset clears the enable, the flag and the irq
		run(64);
		i_rsm_rst_n <= 1'b0;
		repeat (6) @(posedge i_clock);
		i_rsm_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		chk1("irq after resume", 1'b0, o_periodic_irq);
		rd(8'h0B);
		chk8("config after resume", 8'h00, rv);
		rd(8'h0C);
		chk8("flag after resume", 8'h00, rv);
		wr(8'h0B, 8'h40);
		wr(8'h0A, 8'h20);
		irq_seen = 1'b0;
		run(512);
		chk1("rate zero", 1'b0, irq_seen);
		wr(8'h0A, 8'h63);
		got_start = 1'b0;
		run(512);
		chk1("held irq", 1'b0, irq_seen);
		chk1("held update", 1'b0, got_start);
		// bypass 10 stages wraps every 32 ticks
		wr(8'h0A, 8'h40);
		// 23 ticks leave the wrap 9 ticks away, the 24th brings it within the lead
		run(184);
		chk1("pending far from wrap", 1'b0, o_update_pending);
		run(8);
		chk1("pending near wrap", 1'b1, o_update_pending);
		chk1("busy before wrap", 1'b0, o_update_busy);
		run(400);
		chk1("bypass update", 1'b1, got_start);
		chk1("pending at start", 1'b1, pend_at);
		chk1("busy at start", 1'b1, busy_at);
		// bypass 15 stages wraps on every tick, so pending stays up
		got_start = 1'b0;
		wr(8'h0A, 8'h50);
		run(16);
		chk1("bypass15 update", 1'b1, got_start);
		chk1("bypass15 pending", 1'b1, o_update_pending);
		// bypass 5 stages: fastest tap fires on every tick
		wr(8'h0A, 8'h33);
		run(64);
		rd(8'h0C);
		chk8("bypass5 flag", 8'h40, rv);
		wrap_up();
	end

endmodule : rtc_divider_rate_ctrl_tb
